// ### hdl/ssx_exec_core.sv
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`include "ssx_regs.svh"
// Contract
// - save_all_context pushes flags word then enables-high/window, stack_pointer minus 4, clears
// - no interrupt call right after either save; allowed after next instruction
// - save_flags_only pushes flags word, stack_pointer minus 2, then clears it
// - subroutine_exit pops program counter, stack_pointer plus 2 or 4, flags kept
// - software_system_reset zeroes flags, program counter FF2080H, registers to reset
// - software_system_reset holds the reset pin low for 16 state times
// - near_relative_call pushes return counter, stack_pointer minus 2 or 4, adds displacement
// - displacement sign-extended to 16 or 24 bits; may cross pages in 1-Mbyte mode
// - carry_force_one sets carry
// - count is immediate 0 to 0FH or register contents 0 to 1FH
// - left shifts fill zeros; carry holds last bit out
// - double-word left shift copies top bit to carry, doubles, counts down
// - logical right shifts halve unsigned, fill zeros, last bit to carry
// - arithmetic right shifts replicate sign, last bit to carry
// - right shifts clear marker first; set it when carried one meets another cycle
// - word shift opcodes 09, 08, 0A with count then destination bytes
// - byte shift opcodes 19, 18, 1A with the same operand order
// - double-word shift opcodes 0D and 0E with count then long destination
module ssx_exec_core import ssx_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic sys_reset_n_o,
  output logic irq_block_o
);
  ssx_shift_if sh ();

  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d, rd_word, wr_new;
  logic mode1m_q, mode1m_d, hold_q, hold_d, badop_q, badop_d;
  logic [23:0] instr_q, instr_d, pc_q, pc_d;
  logic [31:0] opnd_q, opnd_d;
  logic [4:0] cntreg_q, cntreg_d;
  logic [15:0] pfw_q, pfw_d, iehws_q, iehws_d, stack_pointer_q, stack_pointer_d;
  logic [15:0] stk_q [16];
  logic [15:0] stk_d [16];
  ssx_state_t state_q, state_d;
  logic [4:0] pin_cnt_q, pin_cnt_d;
  logic pin_n_q, pin_n_d;
  logic acc, wr_now, exec_c, fin_c, sysrst_c, sh_go;
  logic [7:0] op, cnt_byte;
  logic [10:0] disp;
  ssx_shift_t sh_kind;
  ssx_width_t sh_width;
  logic [4:0] sh_cnt;

  // byte lane merge for bus writes
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        old[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return old;
  endfunction : merge

  // stack words live at even addresses; sixteen words of flip-flop storage
  function automatic logic [3:0] stk_idx(logic [15:0] p);
    return p[4:1];
  endfunction : stk_idx

  assign acc = wb_cyc_i && wb_stb_i;
  assign wr_now = acc && wb_we_i && ack_q;
  assign op = instr_q[7:0];
  assign cnt_byte = instr_q[15:8];
  assign disp = {op[2:0], cnt_byte};
  // writes take effect on the edge that also carries ack
  assign exec_c = wr_now && wb_adr_i == `SSX_OFS_CTRL && wb_sel_i[0]
                  && wb_dat_i[`SSX_CTRL_GO] && state_q == ssx_idle;
  assign fin_c = (exec_c && !sh_go) || sh.done;
  assign sysrst_c = exec_c && op == `SSX_OP_SYSRST;

  ////////////////////////////////////////////////////////////////////////
  // shift decode: opcode gives kind and width, count byte gives count
  always_comb begin
    sh_go = 1'b1;
    sh_kind = ssx_sh_left;
    sh_width = ssx_w16;
    case (op)
      `SSX_OP_SHL_W: sh_kind = ssx_sh_left;
      `SSX_OP_SHR_W: sh_kind = ssx_sh_lright;
      `SSX_OP_SAR_W: sh_kind = ssx_sh_aright;
      `SSX_OP_SHL_B: begin
        sh_kind = ssx_sh_left;
        sh_width = ssx_w8;
      end
      `SSX_OP_SHR_B: begin
        sh_kind = ssx_sh_lright;
        sh_width = ssx_w8;
      end
      `SSX_OP_SAR_B: begin
        sh_kind = ssx_sh_aright;
        sh_width = ssx_w8;
      end
      `SSX_OP_SHL_D: sh_width = ssx_w32;
      `SSX_OP_SAR_D: begin
        sh_kind = ssx_sh_aright;
        sh_width = ssx_w32;
      end
      default: sh_go = 1'b0;
    endcase
    // small counts are immediate, larger bytes name a register
    sh_cnt = (cnt_byte < `SSX_IMM_LIMIT) ? {1'b0, cnt_byte[3:0]} : cntreg_q;
  end

  assign sh.start = exec_c && sh_go;
  assign sh.kind = sh_kind;
  assign sh.width = sh_width;
  assign sh.count = sh_cnt;
  assign sh.operand = opnd_q;
  assign sh.carry_in = pfw_q[`SSX_PFW_C];

  ssx_shifter u_shifter (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .sh(sh)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus slave: ack one cycle after the request; the read word also feeds write merging
  always_comb begin
    ack_d = acc && !ack_q;
    case (wb_adr_i)
      `SSX_OFS_CTRL: rd_word = {30'h0, mode1m_q, 1'b0};
      `SSX_OFS_INSTR: rd_word = {8'h00, instr_q};
      `SSX_OFS_OPND: rd_word = opnd_q;
      `SSX_OFS_CNTREG: rd_word = {27'h0, cntreg_q};
      `SSX_OFS_PFW: rd_word = {16'h0, pfw_q};
      `SSX_OFS_IEHWS: rd_word = {16'h0, iehws_q};
      `SSX_OFS_STKPTR: rd_word = {16'h0, stack_pointer_q};
      `SSX_OFS_PC: rd_word = {8'h00, pc_q};
      `SSX_OFS_TOP: rd_word = {16'h0, stk_q[stk_idx(stack_pointer_q)]};
      `SSX_OFS_STAT: rd_word = {28'h0, badop_q, ~pin_n_q, hold_q, state_q == ssx_shifting};
      default: rd_word = 32'h0000_0000;
    endcase
    rdat_d = (acc && !ack_q) ? rd_word : rdat_q;
  end
  assign wr_new = merge(rd_word, wb_dat_i, wb_sel_i);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  ////////////////////////////////////////////////////////////////////////
  // architectural state; register writes are ignored while a shift runs
  always_comb begin
    mode1m_d = mode1m_q;
    hold_d = hold_q;
    badop_d = badop_q;
    instr_d = instr_q;
    pc_d = pc_q;
    opnd_d = opnd_q;
    cntreg_d = cntreg_q;
    pfw_d = pfw_q;
    iehws_d = iehws_q;
    stack_pointer_d = stack_pointer_q;
    stk_d = stk_q;
    state_d = state_q;
    if (wr_now && state_q == ssx_idle) begin
      case (wb_adr_i)
        `SSX_OFS_CTRL: mode1m_d = wr_new[1];
        `SSX_OFS_INSTR: instr_d = wr_new[23:0];
        `SSX_OFS_OPND: opnd_d = wr_new;
        `SSX_OFS_CNTREG: cntreg_d = wr_new[4:0];
        `SSX_OFS_PFW: pfw_d = wr_new[15:0];
        `SSX_OFS_IEHWS: iehws_d = wr_new[15:0];
        `SSX_OFS_STKPTR: stack_pointer_d = wr_new[15:0];
        `SSX_OFS_PC: pc_d = wr_new[23:0];
        default: ;
      endcase
    end
    // finishing any instruction lifts the interrupt hold of a save
    if (fin_c) begin
      hold_d = 1'b0;
    end
    if (exec_c) begin
      badop_d = 1'b0;
      case (op)
        `SSX_OP_SAVE_ALL: begin
          stk_d[stk_idx(stack_pointer_q - 16'h0002)] = pfw_q;
          stk_d[stk_idx(stack_pointer_q - 16'h0004)] = iehws_q;
          stack_pointer_d = stack_pointer_q - 16'h0004;
          pfw_d = 16'h0000;
          iehws_d = {8'h00, iehws_q[7:0]};
          hold_d = 1'b1;
        end
        `SSX_OP_SAVE_FLG: begin
          stk_d[stk_idx(stack_pointer_q - 16'h0002)] = pfw_q;
          stack_pointer_d = stack_pointer_q - 16'h0002;
          pfw_d = 16'h0000;
          hold_d = 1'b1;
        end
        `SSX_OP_EXIT: begin
          // wide mode keeps the page byte in the word above the low half
          if (mode1m_q) begin
            pc_d = {stk_q[stk_idx(stack_pointer_q + 16'h0002)][7:0],
                    stk_q[stk_idx(stack_pointer_q)]};
            stack_pointer_d = stack_pointer_q + 16'h0004;
          end else begin
            pc_d = {pc_q[23:16], stk_q[stk_idx(stack_pointer_q)]};
            stack_pointer_d = stack_pointer_q + 16'h0002;
          end
        end
        `SSX_OP_SYSRST: begin
          pfw_d = `SSX_PFW_RST;
          pc_d = `SSX_PC_RST;
          iehws_d = `SSX_IEHWS_RST;
          stack_pointer_d = `SSX_SP_RST;
          mode1m_d = 1'b0;
          hold_d = 1'b0;
        end
        `SSX_OP_CARRY1: pfw_d[`SSX_PFW_C] = 1'b1;
        default: begin
          if (op[7:3] == `SSX_OP_CALL_HI && mode1m_q) begin
            stk_d[stk_idx(stack_pointer_q - 16'h0004)] = pc_q[15:0];
            stk_d[stk_idx(stack_pointer_q - 16'h0002)] = {8'h00, pc_q[23:16]};
            stack_pointer_d = stack_pointer_q - 16'h0004;
            pc_d = pc_q + {{13{disp[10]}}, disp};
          end else if (op[7:3] == `SSX_OP_CALL_HI) begin
            stk_d[stk_idx(stack_pointer_q - 16'h0002)] = pc_q[15:0];
            stack_pointer_d = stack_pointer_q - 16'h0002;
            // the page byte stays put: the sum wraps inside 64 Kbytes
            pc_d = {pc_q[23:16], pc_q[15:0] + {{5{disp[10]}}, disp}};
          end else if (sh_go) begin
            state_d = ssx_shifting;
          end else begin
            badop_d = 1'b1;
          end
        end
      endcase
    end
    // shift write-back keeps operand bits above the width
    if (sh.done) begin
      opnd_d = (opnd_q & ~ssx_mask(sh_width)) | sh.result;
      pfw_d[`SSX_PFW_C] = sh.carry;
      if (sh_kind != ssx_sh_left) begin
        pfw_d[`SSX_PFW_MARK] = sh.marker;
      end
      state_d = ssx_idle;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mode1m_q <= 1'b0;
      hold_q <= 1'b0;
      badop_q <= 1'b0;
      instr_q <= 24'h00_0000;
      pc_q <= `SSX_PC_RST;
      opnd_q <= 32'h0000_0000;
      cntreg_q <= 5'h00;
      pfw_q <= `SSX_PFW_RST;
      iehws_q <= `SSX_IEHWS_RST;
      stack_pointer_q <= `SSX_SP_RST;
      stk_q <= '{default: 16'h0000};
      state_q <= ssx_idle;
    end else begin
      mode1m_q <= mode1m_d;
      hold_q <= hold_d;
      badop_q <= badop_d;
      instr_q <= instr_d;
      pc_q <= pc_d;
      opnd_q <= opnd_d;
      cntreg_q <= cntreg_d;
      pfw_q <= pfw_d;
      iehws_q <= iehws_d;
      stack_pointer_q <= stack_pointer_d;
      stk_q <= stk_d;
      state_q <= state_d;
    end
  end

  assign irq_block_o = hold_q;

  ////////////////////////////////////////////////////////////////////////
  // reset pin pulse; a second reset instruction restarts the full width
  always_comb begin
    pin_cnt_d = pin_cnt_q;
    if (sysrst_c) begin
      pin_cnt_d = 5'(`SSX_PIN_CYCLES);
    end else if (pin_cnt_q != 5'h00) begin
      pin_cnt_d = pin_cnt_q - 5'h01;
    end
    pin_n_d = pin_cnt_d == 5'h00;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pin_cnt_q <= 5'h00;
      pin_n_q <= 1'b1;
    end else begin
      pin_cnt_q <= pin_cnt_d;
      pin_n_q <= pin_n_d;
    end
  end

  assign sys_reset_n_o = pin_n_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic [5:0] low_run_q;
  always_ff @(posedge ref_clk_i) begin
    low_run_q <= (sys_rst_i || pin_n_q || sysrst_c) ? 6'h00 : low_run_q + 6'h01;
  end

  chk_save_all: assert property (
    exec_c && op == `SSX_OP_SAVE_ALL
    |=> stack_pointer_q == $past(stack_pointer_q) - 16'h0004 && pfw_q == 16'h0000
        && iehws_q[15:8] == 8'h00 && stk_q[stk_idx(stack_pointer_q)] == $past(iehws_q))
    else $error("save_all_context effect wrong");
  chk_hold_set: assert property (
    exec_c && (op == `SSX_OP_SAVE_ALL || op == `SSX_OP_SAVE_FLG)
    |=> irq_block_o ##1 (irq_block_o || $past(fin_c)))
    else $error("interrupt hold missing after a save");
  chk_save_flags: assert property (
    exec_c && op == `SSX_OP_SAVE_FLG
    |=> stack_pointer_q == $past(stack_pointer_q) - 16'h0002 && pfw_q == 16'h0000
        && stk_q[stk_idx(stack_pointer_q)] == $past(pfw_q))
    else $error("save_flags_only effect wrong");
  chk_exit_sp: assert property (
    exec_c && op == `SSX_OP_EXIT
    |=> stack_pointer_q == $past(stack_pointer_q) + ($past(mode1m_q) ? 16'h0004 : 16'h0002)
        && pfw_q == $past(pfw_q))
    else $error("subroutine_exit stack step wrong");
  chk_sysrst_pc: assert property (
    sysrst_c |=> pc_q == 24'hff2080 && pfw_q == 16'h0000 && !sys_reset_n_o)
    else $error("software reset state wrong");
  chk_pin_width: assert property (
    !sys_reset_n_o ##1 sys_reset_n_o |-> $past(low_run_q) == 6'd15)
    else $error("reset pin low time is not 16 states");
  chk_call_near: assert property (
    exec_c && op[7:3] == 5'h05 && !mode1m_q
    |=> stack_pointer_q == $past(stack_pointer_q) - 16'h0002
        && pc_q[15:0] == $past(pc_q[15:0]) + {{5{$past(op[2])}}, $past(disp)})
    else $error("near_relative_call result wrong");
  chk_carry_one: assert property (
    exec_c && op == `SSX_OP_CARRY1 |=> pfw_q[`SSX_PFW_C])
    else $error("carry_force_one left carry clear");
  chk_count_pick: assert property (
    sh.start |-> sh.count == (cnt_byte < 8'h10 ? {1'b0, cnt_byte[3:0]} : cntreg_q))
    else $error("shift count source wrong");

  cov_save_all: cover property (exec_c && op == `SSX_OP_SAVE_ALL);
  cov_exit_wide: cover property (exec_c && op == `SSX_OP_EXIT && mode1m_q);
  cov_pin_pulse: cover property ($rose(sys_reset_n_o));
  cov_shift_done: cover property (sh.done && sh.marker);
endmodule : ssx_exec_core

// ### hdl/ssx_pkg.sv
package ssx_pkg;
  typedef enum logic [1:0] {ssx_sh_left, ssx_sh_lright, ssx_sh_aright} ssx_shift_t;
  typedef enum logic [1:0] {ssx_w8, ssx_w16, ssx_w32} ssx_width_t;
  typedef enum logic {ssx_idle, ssx_shifting} ssx_state_t;

  // operand mask for a width
  function automatic logic [31:0] ssx_mask(ssx_width_t w);
    case (w)
      ssx_w8: return 32'h0000_00ff;
      ssx_w16: return 32'h0000_ffff;
      default: return 32'hffff_ffff;
    endcase
  endfunction : ssx_mask
endpackage : ssx_pkg

// ### hdl/ssx_regs.svh
`ifndef SSX_REGS_SVH
`define SSX_REGS_SVH
// register byte offsets on the bus
`define SSX_OFS_CTRL 8'h00
`define SSX_OFS_INSTR 8'h04
`define SSX_OFS_OPND 8'h08
`define SSX_OFS_CNTREG 8'h0c
`define SSX_OFS_PFW 8'h10
`define SSX_OFS_IEHWS 8'h14
`define SSX_OFS_STKPTR 8'h18
`define SSX_OFS_PC 8'h1c
`define SSX_OFS_TOP 8'h20
`define SSX_OFS_STAT 8'h24
// control and status bit positions
`define SSX_CTRL_GO 0
`define SSX_CTRL_MODE1M 1
`define SSX_STAT_BUSY 0
`define SSX_STAT_HOLD 1
`define SSX_STAT_PIN 2
`define SSX_STAT_BADOP 3
// flag positions inside processor_flags_word
`define SSX_PFW_C 11
`define SSX_PFW_MARK 8
// opcodes
`define SSX_OP_SAVE_ALL 8'hf4
`define SSX_OP_SAVE_FLG 8'hf2
`define SSX_OP_EXIT 8'hf0
`define SSX_OP_SYSRST 8'hff
`define SSX_OP_CARRY1 8'hf9
`define SSX_OP_CALL_HI 5'h05
`define SSX_OP_SHL_W 8'h09
`define SSX_OP_SHR_W 8'h08
`define SSX_OP_SAR_W 8'h0a
`define SSX_OP_SHL_B 8'h19
`define SSX_OP_SHR_B 8'h18
`define SSX_OP_SAR_B 8'h1a
`define SSX_OP_SHL_D 8'h0d
`define SSX_OP_SAR_D 8'h0e
`define SSX_IMM_LIMIT 8'h10
// reset values
`define SSX_PC_RST 24'hff2080
`define SSX_SP_RST 16'h0000
`define SSX_PFW_RST 16'h0000
`define SSX_IEHWS_RST 16'h0000
// timing: one state time per core clock
`define SSX_CLK_NS 10
`define SSX_STATE_NS 10
`define SSX_PIN_STATES 16
`define SSX_PIN_CYCLES ((`SSX_PIN_STATES * `SSX_STATE_NS + `SSX_CLK_NS - 1) / `SSX_CLK_NS)
`endif

// ### hdl/ssx_shift_if.sv
`timescale 1ns/1ns
interface ssx_shift_if;
  import ssx_pkg::*;
  logic start;
  ssx_shift_t kind;
  ssx_width_t width;
  logic [4:0] count;
  logic [31:0] operand;
  logic carry_in;
  logic busy;
  logic done;
  logic [31:0] result;
  logic carry;
  logic marker;
  modport core (output start, kind, width, count, operand, carry_in,
                input busy, done, result, carry, marker);
  modport unit (input start, kind, width, count, operand, carry_in,
                output busy, done, result, carry, marker);
endinterface : ssx_shift_if

// ### hdl/ssx_shifter.sv
`timescale 1ns/1ns
module ssx_shifter import ssx_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  ssx_shift_if.unit sh
);
  logic busy_q, busy_d, c_q, c_d, mk_q, mk_d, fresh_q, fresh_d;
  logic [4:0] cnt_q, cnt_d;
  logic [31:0] val_q, val_d, msk;
  ssx_shift_t kind_q, kind_d;
  ssx_width_t w_q, w_d;
  logic top_bit;

  assign msk = ssx_mask(w_q);
  assign top_bit = (w_q == ssx_w8) ? val_q[7] : (w_q == ssx_w16) ? val_q[15] : val_q[31];

  // one bit per cycle, so the count also sets the latency
  always_comb begin
    {busy_d, c_d, mk_d, fresh_d, cnt_d, val_d} = {busy_q, c_q, mk_q, fresh_q, cnt_q, val_q};
    kind_d = kind_q;
    w_d = w_q;
    if (sh.start && !busy_q) begin
      busy_d = 1'b1;
      val_d = sh.operand & ssx_mask(sh.width);
      cnt_d = sh.count;
      c_d = sh.carry_in;
      mk_d = 1'b0;
      fresh_d = 1'b0;
      kind_d = sh.kind;
      w_d = sh.width;
    end else if (busy_q && cnt_q == 5'h00) begin
      busy_d = 1'b0;
    end else if (busy_q) begin
      // a one left in carry by an earlier cycle marks a lost bit
      if (kind_q != ssx_sh_left && fresh_q && c_q) begin
        mk_d = 1'b1;
      end
      fresh_d = 1'b1;
      cnt_d = cnt_q - 5'h01;
      if (kind_q == ssx_sh_left) begin
        c_d = top_bit;
        val_d = (val_q << 1) & msk;
      end else begin
        c_d = val_q[0];
        val_d = val_q >> 1;
        if (kind_q == ssx_sh_aright && top_bit) begin
          val_d = val_q >> 1 | (msk & ~(msk >> 1));
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      {busy_q, c_q, mk_q, fresh_q, cnt_q, val_q} <= '0;
      kind_q <= ssx_sh_left;
      w_q <= ssx_w8;
    end else begin
      {busy_q, c_q, mk_q, fresh_q, cnt_q, val_q} <= {busy_d, c_d, mk_d, fresh_d, cnt_d, val_d};
      kind_q <= kind_d;
      w_q <= w_d;
    end
  end

  assign sh.busy = busy_q;
  assign sh.done = busy_q && cnt_q == 5'h00;
  assign sh.result = val_q;
  assign sh.carry = c_q;
  assign sh.marker = mk_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_count_step: assert property (
    busy_q && cnt_q != 5'h00 |=> cnt_q == $past(cnt_q) - 5'h01)
    else $error("shift count did not fall by one");
  chk_left_carry: assert property (
    busy_q && cnt_q != 5'h00 && kind_q == ssx_sh_left |=> c_q == $past(top_bit))
    else $error("left shift carry is not the old top bit");
  chk_fill_zero: assert property (
    busy_q && cnt_q != 5'h00 && kind_q == ssx_sh_lright
    |=> (val_q & (msk & ~(msk >> 1))) == 32'h0000_0000 && c_q == $past(val_q[0]))
    else $error("logical right shift did not fill zero");
  chk_fill_sign: assert property (
    busy_q && cnt_q != 5'h00 && kind_q == ssx_sh_aright |=> top_bit == $past(top_bit))
    else $error("arithmetic right shift lost the sign");
  chk_mark_clear: assert property (
    sh.start && !busy_q |=> !mk_q)
    else $error("marker not cleared at shift start");
  cov_marker_set: cover property (busy_q ##1 $rose(mk_q));
endmodule : ssx_shifter

// ### tb/ssx_exec_core_tb.sv
`timescale 1ns/1ns
`include "ssx_regs.svh"
module ssx_exec_core_tb;
  logic ref_clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [3:0] wb_sel_i;
  logic wb_ack_o, sys_reset_n_o, irq_block_o;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_cyc = 0;
  int seed = 32'hb444bfa7;
  logic [7:0] ops [8] = '{8'h09, 8'h08, 8'h0a, 8'h19, 8'h18, 8'h1a, 8'h0d, 8'h0e};

  ssx_exec_core ssx_exec_core_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sys_reset_n_o(sys_reset_n_o), .irq_block_o(irq_block_o));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, and a cycle ceiling so a stuck handshake cannot hang the run
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    n_cyc++;
    if (n_cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // request stands until ack is sampled high at a rising edge; data is taken there
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rdchk

  // mode goes in a write ahead of go: the go edge still decodes with the old mode
  task automatic run(input logic [23:0] instr, input logic mode);
    wb(1'b1, `SSX_OFS_CTRL, {30'h0, mode, 1'b0});
    wb(1'b1, `SSX_OFS_INSTR, {8'h00, instr});
    wb(1'b1, `SSX_OFS_CTRL, {30'h0, mode, 1'b1});
  endtask : run

  task automatic test_done();
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // k: 0..2 word, 3..5 byte, 6..7 dword; kd 0 left, 1 logical right, 2 arithmetic right
  function automatic logic [33:0] model(input int k, input logic [31:0] v, input int n,
                                        input logic c, input logic mk);
    int w;
    int kd;
    logic [31:0] m, x;
    w = (k < 3) ? 16 : (k < 6) ? 8 : 32;
    kd = (k == 7) ? 2 : k % 3;
    m = (w == 32) ? 32'hffff_ffff : (32'h1 << w) - 32'h1;
    x = v & m;
    if (kd != 0) mk = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i > 0 && c && kd != 0) mk = 1'b1;
      if (kd == 0) begin
        c = x[w-1];
        x = (x << 1) & m;
      end else begin
        c = x[0];
        x = (x >> 1) | ((kd == 2) ? (x & (32'h1 << (w - 1))) : 32'h0);
      end
    end
    return {mk, c, (v & ~m) | x};
  endfunction : model

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] cb;
    logic [31:0] v;
    logic [15:0] pf;
    logic [33:0] e;
    int n;
    int lowc;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    sys_rst_i = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rdchk(`SSX_OFS_PC, 32'h00ff2080);
    rdchk(8'h40, 32'h0);
    // save_flags_only, then the following instruction lifts the interrupt hold
    wb(1'b1, `SSX_OFS_STKPTR, 32'h10);
    wb(1'b1, `SSX_OFS_PFW, 32'h0000a5c3);
    run(24'hf2, 1'b0);
    @(posedge ref_clk_i);
    chk(irq_block_o, 1'b1);
    rdchk(`SSX_OFS_STKPTR, 32'h0e);
    rdchk(`SSX_OFS_TOP, 32'ha5c3);
    rdchk(`SSX_OFS_PFW, 32'h0);
    run(24'hf9, 1'b0);
    rdchk(`SSX_OFS_PFW, 32'h0800);
    chk(irq_block_o, 1'b0);
    // return in 64-Kbyte mode pops the saved word, flags kept
    run(24'hf0, 1'b0);
    rdchk(`SSX_OFS_STKPTR, 32'h10);
    wb(1'b0, `SSX_OFS_PC, 32'h0);
    chk(q[15:0], 32'ha5c3);
    rdchk(`SSX_OFS_PFW, 32'h0800);
    // save_all_context: two words, enables cleared, window kept
    wb(1'b1, `SSX_OFS_PFW, 32'h0000b7e1);
    wb(1'b1, `SSX_OFS_IEHWS, 32'h00003c5a);
    run(24'hf4, 1'b0);
    @(posedge ref_clk_i);
    chk(irq_block_o, 1'b1);
    rdchk(`SSX_OFS_STKPTR, 32'h0c);
    rdchk(`SSX_OFS_TOP, 32'h3c5a);
    rdchk(`SSX_OFS_PFW, 32'h0);
    rdchk(`SSX_OFS_IEHWS, 32'h005a);
    // short calls at both displacement limits, 1-Mbyte one crosses a page
    wb(1'b1, `SSX_OFS_PC, 32'h1234);
    run(24'h00002c, 1'b0);
    rdchk(`SSX_OFS_STKPTR, 32'h0a);
    rdchk(`SSX_OFS_TOP, 32'h1234);
    wb(1'b0, `SSX_OFS_PC, 32'h0);
    chk(q[15:0], 32'h0e34);
    wb(1'b1, `SSX_OFS_STKPTR, 32'h20);
    wb(1'b1, `SSX_OFS_PC, 32'h12fff0);
    run(24'h00ff2b, 1'b1);
    rdchk(`SSX_OFS_STKPTR, 32'h1c);
    rdchk(`SSX_OFS_PC, 32'h1303ef);
    run(24'hf0, 1'b1);
    rdchk(`SSX_OFS_PC, 32'h12fff0);
    rdchk(`SSX_OFS_STKPTR, 32'h20);
    // every shift opcode: count 0, register count 1fh, then random counts
    for (int i = 0; i < 40; i++) begin
      v = $random(seed);
      pf = $random(seed);
      cb = (i < 8) ? 8'h00 : (i < 16) ? 8'hff : 8'h10 | 8'($random(seed));
      n = (i < 8) ? 0 : (i < 16) ? 31 : $random(seed) & 31;
      if (i >= 24 && i < 32) begin
        cb = 8'($random(seed)) & 8'h0f;
        n = cb;
      end
      wb(1'b1, `SSX_OFS_OPND, v);
      wb(1'b1, `SSX_OFS_PFW, {16'h0, pf});
      wb(1'b1, `SSX_OFS_CNTREG, n);
      run({8'h55, cb, ops[i%8]}, 1'b0);
      // a write while the shift runs must be dropped
      if (i >= 8 && i < 16) wb(1'b1, `SSX_OFS_OPND, 32'h0);
      do wb(1'b0, `SSX_OFS_STAT, 32'h0); while (q[0] === 1'b1);
      e = model(i % 8, v, n, pf[11], pf[8]);
      rdchk(`SSX_OFS_OPND, e[31:0]);
      wb(1'b0, `SSX_OFS_PFW, 32'h0);
      chk(q[11], e[32]);
      chk(q[8], e[33]);
    end
    // system reset: pin low for 16 state times, registers back to reset
    run(24'hff, 1'b1);
    lowc = 0;
    repeat (40) begin
      @(negedge ref_clk_i);
      if (sys_reset_n_o === 1'b0) lowc++;
    end
    chk(lowc, 16);
    rdchk(`SSX_OFS_PC, 32'h00ff2080);
    rdchk(`SSX_OFS_PFW, 32'h0);
    rdchk(`SSX_OFS_STKPTR, 32'h0);
    rdchk(`SSX_OFS_CTRL, 32'h0);
    test_done();
  end
endmodule : ssx_exec_core_tb
